// ==== design/plms_lane_unit.sv ====
// packed lane mask, pack, difference-sum and equality unit
`timescale 1ns/10ps
`include "plms_map.svh"

// Notes on behaviour
// - mask-on-nonzero half: b half where the a half is nonzero, else zero.
// - mask-on-zero byte: b byte where the a byte is zero, else zero.
// - mask-on-zero half: b half where the a half is zero, else zero.
// - byte pack clamps each signed half to 0..255, a halves above b halves.
// - high-byte pack takes upper bytes of a-high, a-low, b-high, b-low.
// - signed half pack clamps each source to 16 bits, a on top, b below.
// - first slot, opcode 0x0 and extension 0x66 decode the signed half pack.
// - low-byte pack takes lower bytes of a-high, a-low, b-high, b-low.
// - accumulating byte sum adds four unsigned byte differences to the dest.
// - accumulating signed half sum adds sign-extended differences to dest.
// - accumulating unsigned half sum adds unsigned differences to dest.
// - plain byte sum gives only the four unsigned byte differences.
// - plain signed half sum gives only the sign-extended differences.
// - plain unsigned half sum gives only the unsigned differences.
// - byte equality writes one per equal byte pair and zero otherwise.
// - half-word equality writes one per equal half pair and zero otherwise.
module plms_lane_unit
    import plms_pkg::*;
(
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        nrst,
    // issue side
    input  wire logic        issue_valid,
    input  wire plms_op_t    issue_op,
    input  wire logic        issue_decode,
    input  wire logic        first_execution_slot,
    input  wire logic [31:0] issue_insn,
    input  wire logic [31:0] src_a,
    input  wire logic [31:0] src_b,
    input  wire logic [31:0] dest_prior,
    // result side
    output logic             result_valid,
    output logic      [31:0] result
);
    logic        valid_d;
    logic        valid_q;
    logic [31:0] result_d;
    logic [31:0] result_q;
    plms_op_t    op;
    logic [`PLMS_MAIN_OPC_W-1:0] main_opcode_field;
    logic [`PLMS_RRR_EXT_W-1:0]  three_register_extension_field;
    logic        half_signed;
    logic [31:0] h_mnz;
    logic [31:0] h_mz;
    logic [31:0] h_eq;
    logic [33:0] h_abs;
    logic [31:0] b_mz;
    logic [31:0] b_mnz;
    logic [31:0] b_eq;
    logic [35:0] b_abs;
    logic [31:0] b_sat;
    logic [31:0] sad_b;
    logic [31:0] sad_h;
    logic [15:0] sat_a;
    logic [15:0] sat_b;
    logic        opc_match;
    logic        ext_match;
    logic [31:0] seq_h;
    logic [9:0]  sad_b_lo;
    logic [9:0]  sad_b_hi;
    logic [31:0] pack_hb;
    logic [31:0] pack_lb;
    logic [31:0] pack_hs;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    always_comb begin
        main_opcode_field = issue_insn[`PLMS_MAIN_OPC_LSB +: `PLMS_MAIN_OPC_W];
        three_register_extension_field =
            issue_insn[`PLMS_RRR_EXT_LSB +: `PLMS_RRR_EXT_W];
        opc_match = (main_opcode_field == `PLMS_MAIN_OPC_PACKH);
        ext_match = (three_register_extension_field == `PLMS_RRR_EXT_PACKH);
        op = issue_op;
        if (issue_decode) begin
            // only one encoding is known; any other word issues nothing
            op = PLMS_OP_NONE;
            if (first_execution_slot && opc_match && ext_match) begin
                op = PLMS_OP_PACK_HS;
            end
        end
        half_signed = (op == PLMS_OP_SADA_H) || (op == PLMS_OP_SAD_H);
    end

    // ------------------------------------------------------------
    // lanes
    // ------------------------------------------------------------
    // half lanes take the sign mode from the op, bytes are always unsigned
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_half
            plms_half_lane u_half (
                .a        (src_a[gi*16 +: 16]),
                .b        (src_b[gi*16 +: 16]),
                .is_signed(half_signed),
                .mask_nz  (h_mnz[gi*16 +: 16]),
                .mask_z   (h_mz[gi*16 +: 16]),
                .eq_one   (h_eq[gi*16 +: 16]),
                .abs_diff (h_abs[gi*17 +: 17])
            );
        end
        for (gi = 0; gi < 4; gi++) begin : g_byte
            logic [7:0] ba;
            logic [7:0] bb;
            logic [15:0] hw;
            logic        hw_neg;
            logic        hw_over;
            assign ba = src_a[gi*8 +: 8];
            assign bb = src_b[gi*8 +: 8];
            // per-lane work, no cross-lane carry
            assign b_mz[gi*8 +: 8]  = (ba == 8'h00) ? bb : 8'h00;
            assign b_mnz[gi*8 +: 8] = (ba != 8'h00) ? bb : 8'h00;
            assign b_eq[gi*8 +: 8]  = (ba == bb) ? 8'h01 : 8'h00;
            // nine-bit terms keep every byte difference whole
            assign b_abs[gi*9 +: 9] = (ba >= bb) ? {1'b0, ba - bb}
                                                 : {1'b0, bb - ba};
            // bytes 3..0 = sat a-high, a-low, b-high, b-low
            assign hw = (gi >= 2) ? src_a[(gi%2)*16 +: 16]
                                  : src_b[(gi%2)*16 +: 16];
            assign hw_neg  = hw[15];
            assign hw_over = (hw[15:8] != 8'h00);
            // negative halves clamp to zero, wide ones to the byte maximum
            assign b_sat[gi*8 +: 8] = hw_neg  ? 8'h00
                                    : hw_over ? `PLMS_SAT_U8_MAX
                                    : hw[7:0];
        end
    endgenerate

    // ------------------------------------------------------------
    // sums and signed clamp
    // ------------------------------------------------------------
    function automatic logic [15:0] sat16(input logic [31:0] v);
        logic pos_over;
        logic neg_over;
        pos_over = !v[31] && (v[31:15] != 17'h0_0000);
        neg_over = v[31] && (v[31:15] != 17'h1_ffff);
        if (pos_over) begin
            sat16 = `PLMS_SAT_S16_MAX;
        end else if (neg_over) begin
            sat16 = `PLMS_SAT_S16_MIN;
        end else begin
            sat16 = v[15:0];
        end
    endfunction

    always_comb begin
        sad_b_lo = 10'(b_abs[8:0]) + 10'(b_abs[17:9]);
        sad_b_hi = 10'(b_abs[26:18]) + 10'(b_abs[35:27]);
        sad_b    = 32'(sad_b_lo) + 32'(sad_b_hi);
        sad_h    = 32'(h_abs[16:0]) + 32'(h_abs[33:17]);
        sat_a    = sat16(src_a);
        sat_b    = sat16(src_b);
    end

    // ------------------------------------------------------------
    // byte and half-word packs
    // ------------------------------------------------------------
    // bytes 3..0 come from a-high, a-low, b-high, b-low
    always_comb begin
        pack_hb = {src_a[31:24], src_a[15:8], src_b[31:24], src_b[15:8]};
        pack_lb = {src_a[23:16], src_a[7:0], src_b[23:16], src_b[7:0]};
        pack_hs = {sat_a, sat_b};
    end

    // ------------------------------------------------------------
    // result select
    // ------------------------------------------------------------
    always_comb begin
        valid_d  = issue_valid && (op != PLMS_OP_NONE);
        result_d = 32'h0000_0000;
        case (op)
            PLMS_OP_MNZB:     result_d = b_mnz;
            PLMS_OP_MNZH:     result_d = h_mnz;
            PLMS_OP_MZB:      result_d = b_mz;
            PLMS_OP_MZH:      result_d = h_mz;
            PLMS_OP_PACK_BSU: result_d = b_sat;
            PLMS_OP_PACK_HB:  result_d = pack_hb;
            PLMS_OP_PACK_HS:  result_d = pack_hs;
            PLMS_OP_PACK_LB:  result_d = pack_lb;
            PLMS_OP_SADA_BU:  result_d = dest_prior + sad_b;
            PLMS_OP_SADA_H:   result_d = dest_prior + sad_h;
            PLMS_OP_SADA_HU:  result_d = dest_prior + sad_h;
            PLMS_OP_SAD_BU:   result_d = sad_b;
            PLMS_OP_SAD_H:    result_d = sad_h;
            PLMS_OP_SAD_HU:   result_d = sad_h;
            PLMS_OP_SEQ_B:    result_d = b_eq;
            PLMS_OP_SEQ_H:    result_d = seq_h;
            default:          result_d = 32'h0000_0000;
        endcase
        // an op that is not taken leaves the last result standing
        if (!valid_d)
            result_d = result_q;
    end

    // ------------------------------------------------------------
    // result register
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            valid_q  <= 1'b0;
            result_q <= 32'h0000_0000;
        end else begin
            valid_q  <= valid_d;
            result_q <= result_d;
        end
    end

    // ------------------------------------------------------------
    // half-word equality
    // ------------------------------------------------------------
    assign seq_h = h_eq;

    assign result_valid = valid_q;
    assign result       = result_q;
endmodule

// ==== shared/plms_map.svh ====
// constants for the packed lane datapath
`ifndef PLMS_MAP_SVH
`define PLMS_MAP_SVH

`define PLMS_MAIN_OPC_LSB   28
`define PLMS_MAIN_OPC_W     3
`define PLMS_MAIN_OPC_PACKH 3'h0
`define PLMS_RRR_EXT_LSB    18
`define PLMS_RRR_EXT_W      9
`define PLMS_RRR_EXT_PACKH  9'h066
`define PLMS_SAT_U8_MAX     8'hff
`define PLMS_SAT_S16_MAX    16'h7fff
`define PLMS_SAT_S16_MIN    16'h8000

`endif

// ==== shared/plms_pkg.sv ====
// types for the packed lane datapath
package plms_pkg;

    typedef enum logic [4:0] {
        PLMS_OP_NONE,
        PLMS_OP_MNZB,
        PLMS_OP_MNZH,
        PLMS_OP_MZB,
        PLMS_OP_MZH,
        PLMS_OP_PACK_BSU,
        PLMS_OP_PACK_HB,
        PLMS_OP_PACK_HS,
        PLMS_OP_PACK_LB,
        PLMS_OP_SADA_BU,
        PLMS_OP_SADA_H,
        PLMS_OP_SADA_HU,
        PLMS_OP_SAD_BU,
        PLMS_OP_SAD_H,
        PLMS_OP_SAD_HU,
        PLMS_OP_SEQ_B,
        PLMS_OP_SEQ_H
    } plms_op_t;

endpackage

// ==== design/plms_half_lane.sv ====
// one 16-bit lane: mask, equality and absolute difference
`timescale 1ns/10ps
module plms_half_lane (
    // operand lanes
    input  wire logic [15:0] a,
    input  wire logic [15:0] b,
    input  wire logic        is_signed,
    // lane results
    output logic      [15:0] mask_nz,
    output logic      [15:0] mask_z,
    output logic      [15:0] eq_one,
    output logic      [16:0] abs_diff
);
    logic signed [17:0] ext_a;
    logic signed [17:0] ext_b;
    logic signed [17:0] diff;

    always_comb begin
        mask_nz  = (a != 16'h0000) ? b : 16'h0000;
        mask_z   = (a == 16'h0000) ? b : 16'h0000;
        eq_one   = (a == b) ? 16'h0001 : 16'h0000;
        ext_a    = is_signed ? {{2{a[15]}}, a} : {2'b00, a};
        ext_b    = is_signed ? {{2{b[15]}}, b} : {2'b00, b};
        diff     = ext_a - ext_b;
        abs_diff = diff[17] ? 17'(-diff) : diff[16:0];
    end
endmodule

// ==== sim/plms_lane_chk.sv ====
// bound checker for the packed lane unit
`timescale 1ns/10ps
module plms_lane_chk
    import plms_pkg::*;
(
    input wire logic        ref_clk,
    input wire logic        nrst,
    input wire logic        issue_valid,
    input wire plms_op_t    issue_op,
    input wire logic        issue_decode,
    input wire logic        first_execution_slot,
    input wire logic [31:0] issue_insn,
    input wire logic [31:0] src_a,
    input wire logic [31:0] src_b,
    input wire logic [31:0] dest_prior,
    input wire logic        result_valid,
    input wire logic [31:0] result
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    logic        dir;
    logic        hit;
    logic [31:0] a_q;
    logic [31:0] b_q;
    assign dir = issue_valid && !issue_decode;
    assign hit = first_execution_slot && issue_insn[30:28] == 3'h0
                 && issue_insn[26:18] == 9'h066;
    always_ff @(posedge ref_clk) begin
        a_q <= src_a;
        b_q <= src_b;
    end
    chk_taken_valid: assert property (dir && issue_op != PLMS_OP_NONE
        |=> result_valid) else $error("result_valid missing");
    chk_decode_hit: assert property (issue_valid && issue_decode
        |=> result_valid == $past(hit)) else $error("decode wrong");
    chk_mnzh_lane: assert property (dir && issue_op == PLMS_OP_MNZH
        |=> result[31:16] == (a_q[31:16] != 16'h0000 ? b_q[31:16]
        : 16'h0000)) else $error("mnzh lane wrong");
    chk_mzb_lane: assert property (dir && issue_op == PLMS_OP_MZB
        |=> result[7:0] == (a_q[7:0] == 8'h00 ? b_q[7:0] : 8'h00))
        else $error("mzb byte wrong");
    chk_mzh_lane: assert property (dir && issue_op == PLMS_OP_MZH
        |=> result[15:0] == (a_q[15:0] == 16'h0000 ? b_q[15:0]
        : 16'h0000)) else $error("mzh lane wrong");
    chk_packhb_bytes: assert property (
        dir && issue_op == PLMS_OP_PACK_HB
        |=> result == {a_q[31:24], a_q[15:8], b_q[31:24], b_q[15:8]})
        else $error("packhb wrong");
    chk_packlb_bytes: assert property (
        dir && issue_op == PLMS_OP_PACK_LB
        |=> result == {a_q[23:16], a_q[7:0], b_q[23:16], b_q[7:0]})
        else $error("packlb wrong");
    chk_seqh_lanes: assert property (dir && issue_op == PLMS_OP_SEQ_H
        |=> result == {15'h0000, a_q[31:16] == b_q[31:16],
                       15'h0000, a_q[15:0] == b_q[15:0]})
        else $error("seqh lanes wrong");
    chk_seqb_byte: assert property (dir && issue_op == PLMS_OP_SEQ_B
        |=> result[7:0] == {7'h00, a_q[7:0] == b_q[7:0]})
        else $error("seqb byte wrong");
endmodule
bind plms_lane_unit plms_lane_chk u_plms_lane_chk (
    .ref_clk(ref_clk), .nrst(nrst), .issue_valid(issue_valid),
    .issue_op(issue_op), .issue_decode(issue_decode),
    .first_execution_slot(first_execution_slot), .issue_insn(issue_insn),
    .src_a(src_a), .src_b(src_b), .dest_prior(dest_prior),
    .result_valid(result_valid), .result(result));

// ==== sim/plms_issue_model.sv ====
// issue pipeline model that feeds the packed lane unit
`timescale 1ns/10ps
module plms_issue_model
    import plms_pkg::*;
(
    input  wire logic        ref_clk,
    output logic             issue_valid,
    output plms_op_t         issue_op,
    output logic             issue_decode,
    output logic             first_execution_slot,
    output logic      [31:0] issue_insn,
    output logic      [31:0] src_a,
    output logic      [31:0] src_b,
    output logic      [31:0] dest_prior,
    input  wire logic        result_valid,
    input  wire logic [31:0] result
);
    initial begin
        {issue_valid, issue_decode, first_execution_slot} = 3'h1;
        issue_op = PLMS_OP_NONE;
        {issue_insn, src_a, src_b, dest_prior} = '0;
    end
    // slot flag changes off the sampling edge, between ops
    task automatic set_slot(input logic s);
        @(negedge ref_clk);
        first_execution_slot = s;
    endtask
    // one op per call; result sampled half a cycle after the take edge
    task automatic issue(input plms_op_t op, input logic dec,
                         input logic [31:0] ins, a, b, d,
                         output logic rv, output logic [31:0] res);
        @(negedge ref_clk);
        issue_valid = 1'b1;
        issue_op = op;
        issue_decode = dec;
        {issue_insn, src_a, src_b, dest_prior} = {ins, a, b, d};
        @(negedge ref_clk);
        rv = result_valid;
        res = result;
        issue_valid = 1'b0;
        // stale operands must not look valid
        {src_a, src_b, dest_prior} = ~{src_a, src_b, dest_prior};
    endtask
endmodule

// ==== sim/testbench.sv ====
// self-checking bench for the packed lane unit
`timescale 1ns/10ps
module testbench;
    import plms_pkg::*;
    logic        ref_clk = 1'b0;
    logic        nrst;
    logic        issue_valid, issue_decode, first_execution_slot;
    logic        result_valid, rv;
    plms_op_t    issue_op;
    logic [31:0] issue_insn, src_a, src_b, dest_prior, result, res;
    int          failures = 0;
    int          check_count = 0;
    plms_lane_unit u_plms_lane_unit (.ref_clk(ref_clk), .nrst(nrst),
        .issue_valid(issue_valid), .issue_op(issue_op),
        .issue_decode(issue_decode),
        .first_execution_slot(first_execution_slot),
        .issue_insn(issue_insn), .src_a(src_a), .src_b(src_b),
        .dest_prior(dest_prior), .result_valid(result_valid),
        .result(result));
    plms_issue_model u_plms_issue_model (.ref_clk(ref_clk),
        .issue_valid(issue_valid), .issue_op(issue_op),
        .issue_decode(issue_decode),
        .first_execution_slot(first_execution_slot),
        .issue_insn(issue_insn), .src_a(src_a), .src_b(src_b),
        .dest_prior(dest_prior), .result_valid(result_valid),
        .result(result));
    always #20 ref_clk = ~ref_clk;
    task automatic check32(input string name, input logic [31:0] exp, got);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic run(input string name, input plms_op_t op,
                       input logic [31:0] a, b, d, exp);
        u_plms_issue_model.issue(op, 1'b0, '0, a, b, d, rv, res);
        check32({name, " valid"}, 32'h0000_0001, {31'h0, rv});
        check32(name, exp, res);
    endtask
    task automatic t_mask;
        run("mnzb", PLMS_OP_MNZB, 32'h0001_00ff, 32'h1122_3344, '0,
            32'h0022_0044);
        run("mnzh", PLMS_OP_MNZH, 32'h0000_0001, 32'habcd_1234, '0,
            32'h0000_1234);
        run("mzb", PLMS_OP_MZB, 32'h0001_00ff, 32'h1122_3344, '0,
            32'h1100_3300);
        run("mzh", PLMS_OP_MZH, 32'h0000_0100, 32'habcd_1234, '0,
            32'habcd_0000);
    endtask
    task automatic t_pack;
        run("packbs", PLMS_OP_PACK_BSU, 32'hff80_0100, 32'h007f_00ff, '0,
            32'h00ff_7fff);
        run("packhb", PLMS_OP_PACK_HB, 32'h1122_3344, 32'h5566_7788, '0,
            32'h1133_5577);
        run("packlb", PLMS_OP_PACK_LB, 32'h1122_3344, 32'h5566_7788, '0,
            32'h2244_6688);
        run("packhs", PLMS_OP_PACK_HS, 32'h0001_2345, 32'hffff_0000, '0,
            32'h7fff_8000);
    endtask
    task automatic t_sad;
        logic [31:0] a = 32'h0110_ff05;
        logic [31:0] b = 32'h0205_0107;
        run("sadab", PLMS_OP_SADA_BU, a, b, 32'hffff_fff0,
            32'h0000_00fc);
        run("sadah", PLMS_OP_SADA_H, a, b, 32'h0000_0010,
            32'h0000_0307);
        run("sadahu", PLMS_OP_SADA_HU, a, b, 32'h0000_0010,
            32'h0000_ff03);
        run("sadb", PLMS_OP_SAD_BU, a, b, 32'h1111_1111,
            32'h0000_010c);
        run("sadh", PLMS_OP_SAD_H, a, b, 32'h1111_1111,
            32'h0000_02f7);
        run("sadhu", PLMS_OP_SAD_HU, a, b, 32'h1111_1111,
            32'h0000_fef3);
    endtask
    task automatic t_seq_decode;
        run("seqb", PLMS_OP_SEQ_B, 32'h8011_2233, 32'h8011_0033, '0,
            32'h0101_0001);
        run("seqh", PLMS_OP_SEQ_H, 32'h8000_1234, 32'h8000_1235, '0,
            32'h0001_0000);
        u_plms_issue_model.issue(PLMS_OP_NONE, 1'b1, 32'h0198_0000,
            32'h8000_0000, 32'h0000_0005, '0, rv, res);
        check32("dec valid", 32'h0000_0001, {31'h0, rv});
        check32("dec packhs", 32'h8000_0005, res);
        u_plms_issue_model.issue(PLMS_OP_NONE, 1'b1, 32'h019c_0000,
            32'h1234_5678, 32'h0000_0005, '0, rv, res);
        check32("bad ext valid", 32'h0000_0000, {31'h0, rv});
        check32("bad ext held", 32'h8000_0005, res);
        u_plms_issue_model.set_slot(1'b0);
        u_plms_issue_model.issue(PLMS_OP_NONE, 1'b1, 32'h0198_0000,
            32'h1234_5678, 32'h0000_0005, '0, rv, res);
        check32("bad slot valid", 32'h0000_0000, {31'h0, rv});
        check32("bad slot held", 32'h8000_0005, res);
        u_plms_issue_model.set_slot(1'b1);
    endtask
    task automatic report_and_stop;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        #200000;
        failures++;
        report_and_stop;
    end
    initial begin
        nrst = 1'b0;
        repeat (4) @(posedge ref_clk);
        @(negedge ref_clk);
        nrst = 1'b1;
        t_mask;
        t_pack;
        t_sad;
        t_seq_decode;
        report_and_stop;
    end
endmodule
